/* core/hbr_defines.vh */
`ifndef HBR_DEFINES_VH
`define HBR_DEFINES_VH
// queue and deferral limits
`define HBR_IOQ_DEPTH      12
`define HBR_IOQ_CNT_W      4
`define HBR_IOQ_PTR_W      4
`define HBR_IOQ_LAST       4'hB
`define HBR_DEFER_MAX      2'h2
// address and data widths
`define HBR_ADDR_W         32
`define HBR_DATA_W         64
`define HBR_LINE_MASK      32'hFFFFFFC0
`define HBR_GRP_W          16
// request entry layout: {defer, tgt[2:0], addr[31:0]}
`define HBR_ENT_W          36
// host request kinds
`define HBR_KIND_MEM       1'h0
`define HBR_KIND_IO        1'h1
// targets, one-hot except dram, which is all zeros
`define HBR_TGT_W          3
`define HBR_TGT_GFX        3'h1
`define HBR_TGT_CFG        3'h2
`define HBR_TGT_HUB        3'h4
`define HBR_TGT_DRAM       3'h0
// inbound sources
`define HBR_SRC_GFX_AGP    2'h0
`define HBR_SRC_GFX_PCI    2'h1
`define HBR_SRC_HUB        2'h2
// interrupt message window
`define HBR_MSG_BASE       32'hFEE00000
`define HBR_MSG_MASK       32'hFFF00000
// aperture translation table
`define HBR_PAGE_SHIFT     12
`define HBR_GART_AW        6
`define HBR_PAGE_W         20
`endif

/* core/hbr_xlate_mem.v */
`timescale 1ns/1ps
`include "hbr_defines.vh"
// aperture translation table, registered read
module hbr_xlate_mem (
    input  wire                       clock_i,
    input  wire                       wr_en_i,
    input  wire [`HBR_GART_AW-1:0]    wr_idx_i,
    input  wire [`HBR_PAGE_W-1:0]     wr_page_i,
    input  wire [`HBR_GART_AW-1:0]    rd_idx_i,
    output reg  [`HBR_PAGE_W-1:0]     rd_page_o
);
    reg [`HBR_PAGE_W-1:0] mem_r [0:(1<<`HBR_GART_AW)-1];

    // one write and one read port; read data a cycle late
    always @(posedge clock_i) begin
        if (wr_en_i) begin
            mem_r[wr_idx_i] <= wr_page_i;
        end
        rd_page_o <= mem_r[rd_idx_i];
    end
endmodule // hbr_xlate_mem

/* core/hbr_inv_code.v */
`timescale 1ns/1ps
`include "hbr_defines.vh"
// bus inversion coding of one 16-bit group
module hbr_inv_code (
    input  wire [`HBR_GRP_W-1:0] data_i,
    input  wire                  enc_i,
    input  wire                  inv_i,
    output wire [`HBR_GRP_W-1:0] data_o,
    output wire                  inv_o
);
    integer                      k;
    reg     [4:0]                ones;

    // count zeros; invert a group with more than half driven low
    always @* begin
        ones = 5'h0;
        for (k = 0; k < `HBR_GRP_W; k = k + 1) begin
            ones = ones + {4'h0, ~data_i[k]};
        end
    end
    assign inv_o  = enc_i & (ones > 5'h8);
    assign data_o = (enc_i ? inv_o : inv_i) ? ~data_i : data_i;
endmodule // hbr_inv_code

/* core/hbr_router.v */
`timescale 1ns/1ps
`include "hbr_defines.vh"
module hbr_router (
    input  wire                       clock_i,
    input  wire                       rst_n_i,
    input  wire                       bus_clk_i,     // host strobe clock, sampled
    input  wire                       req_valid_i,
    input  wire                       req_kind_i,
    input  wire                       req_defer_i,
    input  wire [`HBR_ADDR_W-1:0]     req_addr_i,
    input  wire                       retire_i,
    input  wire [`HBR_TGT_W-1:0]      defer_done_i,
    input  wire [`HBR_ADDR_W-1:0]     gfx_io_base_i,
    input  wire [`HBR_ADDR_W-1:0]     gfx_io_lim_i,
    input  wire [`HBR_ADDR_W-1:0]     cfg_io_base_i,
    input  wire [`HBR_ADDR_W-1:0]     cfg_io_lim_i,
    input  wire [`HBR_ADDR_W-1:0]     gfx_mem_base_i,
    input  wire [`HBR_ADDR_W-1:0]     gfx_mem_lim_i,
    input  wire [`HBR_ADDR_W-1:0]     aper_base_i,
    input  wire [`HBR_ADDR_W-1:0]     aper_lim_i,
    input  wire                       gart_wr_i,
    input  wire [`HBR_GART_AW-1:0]    gart_idx_i,
    input  wire [`HBR_PAGE_W-1:0]     gart_page_i,
    input  wire                       in_valid_i,
    input  wire [1:0]                 in_src_i,
    input  wire                       in_write_i,
    input  wire [`HBR_ADDR_W-1:0]     in_addr_i,
    input  wire                       mem_req_i,
    input  wire [`HBR_DATA_W-1:0]     hd_data_i,
    input  wire [3:0]                 hd_inv_i,
    input  wire [`HBR_DATA_W-1:0]     tx_data_i,
    output reg                        req_ready_o,
    output reg                        req_retry_o,
    output reg                        route_valid_o,
    output reg  [`HBR_TGT_W-1:0]      route_tgt_o,
    output reg  [`HBR_ADDR_W-1:0]     route_addr_o,
    output reg                        route_defer_o,
    output reg  [`HBR_IOQ_CNT_W-1:0]  ioq_count_o,
    output reg                        out_valid_o,
    output reg  [`HBR_ADDR_W-1:0]     out_addr_o,
    output reg                        out_snoop_o,
    output reg                        out_msg_o,
    output reg  [3:0]                 grant_o,
    output reg  [`HBR_DATA_W-1:0]     rx_data_o,
    output reg  [`HBR_DATA_W-1:0]     hd_data_o,
    output reg  [3:0]                 hd_inv_o,
    output reg                        bus_edge_o
);
    // arbiter states, one-hot
    localparam ST_HOST = 4'h1;
    localparam ST_MEM  = 4'h2;
    localparam ST_GFX  = 4'h4;
    localparam ST_HUB  = 4'h8;

    reg  [`HBR_ENT_W-1:0]     ioq_r [0:`HBR_IOQ_DEPTH-1];
    reg  [`HBR_IOQ_PTR_W-1:0] wr_ptr_r;
    reg  [`HBR_IOQ_PTR_W-1:0] rd_ptr_r;
    reg  [`HBR_IOQ_CNT_W-1:0] cnt_r;
    reg  [`HBR_TGT_W-1:0]     dfr_busy_r;
    reg  [1:0]                dfr_cnt_r;
    reg  [3:0]                state_r;
    reg  [3:0]                state_nxt;
    reg                       clk_s1_r;
    reg                       clk_s2_r;
    reg                       clk_s3_r;
    reg                       in_pend_r;
    reg  [`HBR_ADDR_W-1:0]    in_addr_r;
    reg                       in_snoop_r;
    reg                       in_msg_r;
    reg                       in_aper_r;
    reg  [`HBR_TGT_W-1:0]     tgt;
    reg                       defer_ok;
    wire                      full;
    wire                      take;
    wire                      enq;
    wire                      pop;
    wire [`HBR_IOQ_CNT_W-1:0] cnt_nxt;
    wire [1:0]                grant_nxt_in;
    wire [`HBR_PAGE_W-1:0]    xl_page;
    wire [`HBR_ADDR_W-1:0]    aper_off;
    wire [`HBR_ADDR_W-1:0]    in_line;
    wire                      in_aper;
    wire                      in_is_msg;
    wire [`HBR_DATA_W-1:0]    rx_dec;
    wire [`HBR_DATA_W-1:0]    tx_enc;
    wire [3:0]                tx_inv;

    assign full = (cnt_r == `HBR_IOQ_DEPTH);
    // ready already carries host turn and room; a request held while ready stays high is taken every cycle
    assign take = req_valid_i & req_ready_o & ~full & state_r[0];
    assign pop  = retire_i & (cnt_r != {`HBR_IOQ_CNT_W{1'b0}});
    assign enq  = take & ~(req_defer_i & ~defer_ok);
    assign cnt_nxt = cnt_r + {3'h0, enq} - {3'h0, pop};

    // address decode of the host request
    always @* begin
        tgt = `HBR_TGT_DRAM;
        if (req_kind_i == `HBR_KIND_IO) begin
            if (req_addr_i >= gfx_io_base_i && req_addr_i <= gfx_io_lim_i) begin
                tgt = `HBR_TGT_GFX;
            end else if (req_addr_i >= cfg_io_base_i && req_addr_i <= cfg_io_lim_i) begin
                tgt = `HBR_TGT_CFG;
            end else begin
                tgt = `HBR_TGT_HUB;                           // subtractive
            end
        end else if (req_addr_i >= gfx_mem_base_i && req_addr_i <= gfx_mem_lim_i) begin
            tgt = `HBR_TGT_GFX;
        end
    end

    // dram takes no busy slot but counts as in flight; a busy slot or two in flight means retry
    always @* begin
        defer_ok = (dfr_cnt_r < `HBR_DEFER_MAX) &&
                   ((tgt == `HBR_TGT_DRAM) || ((dfr_busy_r & tgt) == {`HBR_TGT_W{1'b0}}));
    end

    // in-order queue; entries hold full 32-bit addresses
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= {`HBR_IOQ_PTR_W{1'b0}};
            rd_ptr_r <= {`HBR_IOQ_PTR_W{1'b0}};
            cnt_r    <= {`HBR_IOQ_CNT_W{1'b0}};
        end else begin
            if (enq) begin
                ioq_r[wr_ptr_r] <= {req_defer_i, tgt, req_addr_i};
                wr_ptr_r <= (wr_ptr_r == `HBR_IOQ_LAST) ? {`HBR_IOQ_PTR_W{1'b0}}
                                                       : wr_ptr_r + 4'h1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == `HBR_IOQ_LAST) ? {`HBR_IOQ_PTR_W{1'b0}}
                                                       : rd_ptr_r + 4'h1;
            end
            cnt_r <= cnt_nxt;
        end
    end

    // deferral tracking; a completion and a new deferral in one cycle both count
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            dfr_busy_r <= {`HBR_TGT_W{1'b0}};
            dfr_cnt_r  <= 2'h0;
        end else begin
            dfr_busy_r <= (dfr_busy_r & ~defer_done_i) |
                          ((take && req_defer_i && defer_ok) ? tgt : {`HBR_TGT_W{1'b0}});
            dfr_cnt_r  <= dfr_cnt_r
                        + {1'b0, take && req_defer_i && defer_ok}
                        - {1'b0, defer_done_i != {`HBR_TGT_W{1'b0}}};
        end
    end

    // host side outputs; all registered
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            req_ready_o   <= 1'b0;
            req_retry_o   <= 1'b0;
            route_valid_o <= 1'b0;
            route_tgt_o   <= `HBR_TGT_DRAM;
            route_addr_o  <= {`HBR_ADDR_W{1'b0}};
            route_defer_o <= 1'b0;
            ioq_count_o   <= {`HBR_IOQ_CNT_W{1'b0}};
        end else begin
            // built from next state and count so ready and count never disagree
            req_ready_o   <= state_nxt[0] & (cnt_nxt != `HBR_IOQ_DEPTH);
            req_retry_o   <= take & req_defer_i & ~defer_ok;
            route_valid_o <= pop;
            route_tgt_o   <= ioq_r[rd_ptr_r][34:32];
            route_addr_o  <= ioq_r[rd_ptr_r][31:0];
            route_defer_o <= ioq_r[rd_ptr_r][35];
            ioq_count_o   <= cnt_nxt;
        end
    end

    // fixed rotation across the four initiators; the host keeps its turn while it has a request and the queue has room
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_HOST: if (!req_valid_i || full) state_nxt = ST_MEM;
            ST_MEM:  state_nxt = ST_GFX;
            // one grant per inbound turn; a request still held next cycle is not taken again
            ST_GFX:  state_nxt = ST_HUB;
            ST_HUB:  state_nxt = ST_HOST;
            default: state_nxt = ST_HOST;
        endcase
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r <= ST_HOST;
            grant_o <= 4'h0;
        end else begin
            state_r <= state_nxt;
            grant_o <= {state_r[3] & in_valid_i & (in_src_i == `HBR_SRC_HUB),
                        state_r[2] & in_valid_i & (in_src_i != `HBR_SRC_HUB),
                        state_r[1] & mem_req_i, take};
        end
    end

    // inbound accesses: line-aligned, aperture translated, snooped by semantics
    assign in_line   = in_addr_i & `HBR_LINE_MASK;
    assign in_aper   = (in_addr_i >= aper_base_i) && (in_addr_i <= aper_lim_i);
    assign aper_off  = in_addr_i - aper_base_i;
    assign in_is_msg = in_write_i && ((in_addr_i & `HBR_MSG_MASK) == `HBR_MSG_BASE) &&
                       (in_src_i != `HBR_SRC_GFX_AGP);

    hbr_xlate_mem u_xlate (
        .clock_i   (clock_i),
        .wr_en_i   (gart_wr_i),
        .wr_idx_i  (gart_idx_i),
        .wr_page_i (gart_page_i),
        .rd_idx_i  (aper_off[`HBR_PAGE_SHIFT+`HBR_GART_AW-1:`HBR_PAGE_SHIFT]),
        .rd_page_o (xl_page)
    );

    // stage one captures, stage two uses the table read
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            in_pend_r   <= 1'b0;
            in_addr_r   <= {`HBR_ADDR_W{1'b0}};
            in_snoop_r  <= 1'b0;
            in_msg_r    <= 1'b0;
            in_aper_r   <= 1'b0;
            out_valid_o <= 1'b0;
            out_addr_o  <= {`HBR_ADDR_W{1'b0}};
            out_snoop_o <= 1'b0;
            out_msg_o   <= 1'b0;
        end else begin
            in_pend_r   <= |grant_nxt_in;
            in_addr_r   <= in_line;
            in_msg_r    <= in_is_msg;
            in_aper_r   <= in_aper & ~in_is_msg;
            in_snoop_r  <= ~in_is_msg & (in_src_i != `HBR_SRC_GFX_AGP);
            out_valid_o <= in_pend_r;
            out_addr_o  <= in_aper_r ? {xl_page, in_addr_r[`HBR_PAGE_SHIFT-1:0]}
                                     : in_addr_r;
            out_snoop_o <= in_pend_r & in_snoop_r;
            out_msg_o   <= in_pend_r & in_msg_r;
        end
    end

    // inbound grants of this cycle, shared with the capture stage
    assign grant_nxt_in = {state_r[3] & in_valid_i & (in_src_i == `HBR_SRC_HUB),
                           state_r[2] & in_valid_i & (in_src_i != `HBR_SRC_HUB)};

    // data path: four 16-bit groups per transfer, no parity anywhere
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : grp
            hbr_inv_code u_dec (
                .data_i (hd_data_i[g*`HBR_GRP_W +: `HBR_GRP_W]),
                .enc_i  (1'b0),
                .inv_i  (hd_inv_i[g]),
                .data_o (rx_dec[g*`HBR_GRP_W +: `HBR_GRP_W]),
                .inv_o  ()
            );
            hbr_inv_code u_enc (
                .data_i (tx_data_i[g*`HBR_GRP_W +: `HBR_GRP_W]),
                .enc_i  (1'b1),
                .inv_i  (1'b0),
                .data_o (tx_enc[g*`HBR_GRP_W +: `HBR_GRP_W]),
                .inv_o  (tx_inv[g])
            );
        end
    endgenerate

    // registered data; the bus strobe is resampled twice before its edge is used
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            rx_data_o  <= {`HBR_DATA_W{1'b0}};
            hd_data_o  <= {`HBR_DATA_W{1'b0}};
            hd_inv_o   <= 4'h0;
            clk_s1_r   <= 1'b0;
            clk_s2_r   <= 1'b0;
            clk_s3_r   <= 1'b0;
            bus_edge_o <= 1'b0;
        end else begin
            rx_data_o  <= rx_dec;
            hd_data_o  <= tx_enc;
            hd_inv_o   <= tx_inv;
            clk_s1_r   <= bus_clk_i;
            clk_s2_r   <= clk_s1_r;
            clk_s3_r   <= clk_s2_r;
            bus_edge_o <= clk_s2_r & ~clk_s3_r;
        end
    end
endmodule // hbr_router

/* testbench/hbr_router_asserts.sv */
`timescale 1ns/1ps
`include "hbr_defines.vh"
// port-level checks on the router
module hbr_router_asserts (
    input wire                      clock_i,
    input wire                      rst_n_i,
    input wire                      req_valid_i,
    input wire                      req_defer_i,
    input wire                      retire_i,
    input wire                      req_ready_o,
    input wire                      req_retry_o,
    input wire                      route_valid_o,
    input wire [`HBR_IOQ_CNT_W-1:0] ioq_count_o,
    input wire                      out_valid_o,
    input wire [`HBR_ADDR_W-1:0]    out_addr_o,
    input wire                      out_snoop_o,
    input wire                      out_msg_o,
    input wire [3:0]                grant_o,
    input wire [`HBR_DATA_W-1:0]    hd_data_o,
    input wire [3:0]                hd_inv_o
);
    // a coded group never carries more than 8 zeros; a flagged one has 9+ ones
    function automatic bit grp_ok(input [15:0] d, input v);
        grp_ok = $countones(d) >= (v ? 9 : 8);
    endfunction
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_count_max: assert property (ioq_count_o <= `HBR_IOQ_DEPTH)
        else $error("queue count above depth");
    a_count_step: assert property (ioq_count_o == $past(ioq_count_o)
        || ioq_count_o == $past(ioq_count_o) + 4'h1 || ioq_count_o + 4'h1 == $past(ioq_count_o))
        else $error("queue count jumped");
    a_full_stall: assert property (ioq_count_o == `HBR_IOQ_DEPTH |-> !req_ready_o)
        else $error("ready while queue full");
    a_route_cause: assert property (route_valid_o |-> $past(retire_i))
        else $error("route without retire");
    a_retry_cause: assert property (req_retry_o |-> $past(req_valid_i && req_defer_i)
        || $past(req_valid_i && req_defer_i, 2))
        else $error("retry without deferred request");
    a_grant_one: assert property ($onehot0(grant_o))
        else $error("several grants at once");
    a_grant_host: assert property (grant_o[0] |-> $past(req_valid_i))
        else $error("host grant without request");
    a_msg_clean: assert property (out_valid_o && out_msg_o |-> !out_snoop_o)
        else $error("interrupt message snooped");
    a_line_align: assert property (out_valid_o && !out_msg_o |-> out_addr_o[5:0] == 6'h00)
        else $error("inbound address not line aligned");
    a_inv_code: assert property ($past(rst_n_i, 2) |-> grp_ok(hd_data_o[15:0], hd_inv_o[0])
        && grp_ok(hd_data_o[31:16], hd_inv_o[1]) && grp_ok(hd_data_o[47:32], hd_inv_o[2])
        && grp_ok(hd_data_o[63:48], hd_inv_o[3]))
        else $error("inversion coding off threshold");
endmodule // hbr_router_asserts

bind hbr_router hbr_router_asserts u_chk (
    .clock_i, .rst_n_i, .req_valid_i, .req_defer_i, .retire_i, .req_ready_o,
    .req_retry_o, .route_valid_o, .ioq_count_o, .out_valid_o, .out_addr_o,
    .out_snoop_o, .out_msg_o, .grant_o, .hd_data_o, .hd_inv_o
);

/* testbench/hbr_cpu_model.sv */
`timescale 1ns/1ps
`include "hbr_defines.vh"
// lone processor on the host bus: strobe clock and coded data lanes
module hbr_cpu_model (
    input  wire [`HBR_DATA_W-1:0] wr_data_i,
    input  wire [`HBR_DATA_W-1:0] hd_data_i,
    input  wire [3:0]             hd_inv_i,
    output reg                    bus_clk_o,
    output reg  [`HBR_DATA_W-1:0] hd_data_o,
    output reg  [3:0]             hd_inv_o,
    output reg  [`HBR_DATA_W-1:0] rd_data_o
);
    integer g;
    // free running, offset so its edges keep a fixed phase against the core clock
    initial begin
        bus_clk_o = 1'b0;
        #13;
        forever #32 bus_clk_o = ~bus_clk_o;
    end
    // invert a group holding more than 8 zeros; undo flagged groups on read
    always @* begin
        for (g = 0; g < 4; g = g + 1) begin
            hd_inv_o[g] = $countones(wr_data_i[g*16 +: 16]) < 8;
            hd_data_o[g*16 +: 16] = wr_data_i[g*16 +: 16] ^ {16{hd_inv_o[g]}};
            rd_data_o[g*16 +: 16] = hd_data_i[g*16 +: 16] ^ {16{hd_inv_i[g]}};
        end
    end
endmodule // hbr_cpu_model

/* testbench/hbr_router_tb.sv */
`timescale 1ns/1ps
`include "hbr_defines.vh"
`define CHK(nm, exp, got) begin checks = checks + 1; if ((got) !== (exp)) begin \
    fail_count = fail_count + 1; $display("mismatch %s exp %h got %h", nm, exp, got); end end
module hbr_router_tb;
    reg         clock_i = 1'b0, rst_n_i = 1'b0, retire_i = 1'b0, gart_wr_i = 1'b0;
    reg         req_valid_i = 1'b0, req_kind_i = 1'b0, req_defer_i = 1'b0;
    reg         in_valid_i = 1'b0, in_write_i = 1'b0, mem_req_i = 1'b0;
    reg  [31:0] req_addr_i = 32'h0, in_addr_i = 32'h0;
    reg  [31:0] gfx_io_base_i = 32'h1000, gfx_io_lim_i = 32'h1FFF;
    reg  [31:0] cfg_io_base_i = 32'h0CF8, cfg_io_lim_i = 32'h0CFF;
    reg  [31:0] gfx_mem_base_i = 32'hD0000000, gfx_mem_lim_i = 32'hDFFFFFFF;
    reg  [31:0] aper_base_i = 32'hE0000000, aper_lim_i = 32'hE003FFFF;
    reg  [2:0]  defer_done_i = 3'h0;
    reg  [5:0]  gart_idx_i = 6'h0;
    reg  [19:0] gart_page_i = 20'h0;
    reg  [1:0]  in_src_i = 2'h0;
    reg  [63:0] tx_data_i = 64'h0, cpu_val = 64'h0;
    wire        req_ready_o, req_retry_o, route_valid_o, route_defer_o, out_valid_o;
    wire        out_snoop_o, out_msg_o, bus_clk_i, bus_edge_o;
    wire [2:0]  route_tgt_o;
    wire [31:0] route_addr_o, out_addr_o;
    wire [3:0]  ioq_count_o, grant_o, hd_inv_o, hd_inv_i;
    wire [63:0] rx_data_o, hd_data_o, hd_data_i, rd_data;
    reg  [35:0] exq[$];
    integer     fail_count = 0, checks = 0, n;
    always #2 clock_i = ~clock_i;
    hbr_router u_dut (.clock_i, .rst_n_i, .bus_clk_i, .req_valid_i, .req_kind_i,
        .req_defer_i, .req_addr_i, .retire_i, .defer_done_i, .gfx_io_base_i, .gfx_io_lim_i,
        .cfg_io_base_i, .cfg_io_lim_i, .gfx_mem_base_i, .gfx_mem_lim_i, .aper_base_i,
        .aper_lim_i, .gart_wr_i, .gart_idx_i, .gart_page_i, .in_valid_i, .in_src_i,
        .in_write_i, .in_addr_i, .mem_req_i, .hd_data_i, .hd_inv_i, .tx_data_i, .req_ready_o,
        .req_retry_o, .route_valid_o, .route_tgt_o, .route_addr_o, .route_defer_o,
        .ioq_count_o, .out_valid_o, .out_addr_o, .out_snoop_o, .out_msg_o, .grant_o,
        .rx_data_o, .hd_data_o, .hd_inv_o, .bus_edge_o);
    hbr_cpu_model u_cpu (.wr_data_i(cpu_val), .hd_data_i(hd_data_o), .hd_inv_i(hd_inv_o),
        .bus_clk_o(bus_clk_i), .hd_data_o(hd_data_i), .hd_inv_o(hd_inv_i), .rd_data_o(rd_data));
    task summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // a wait that ran out ends the run at once
    task hang;
        fail_count = fail_count + 1;
        $display("mismatch handshake exp done got none");
        summarize;
    endtask
    // host request held until ready is sampled, then watch for a retry
    task do_req(input k, input d, input [31:0] a, input [2:0] t, input r);
        integer i;
        reg     seen;
        begin
            req_kind_i <= k;
            req_defer_i <= d;
            req_addr_i <= a;
            req_valid_i <= 1'b1;
            i = 0;
            do begin @(posedge clock_i); i = i + 1; end while (req_ready_o !== 1'b1 && i < 60);
            if (i == 60) hang;
            req_valid_i <= 1'b0;
            seen = 1'b0;
            repeat (3) begin @(posedge clock_i); seen = seen | req_retry_o; end
            `CHK("retry", r, seen)
            if (!r) exq.push_back({d, t, a});
        end
    endtask
    // retire the oldest entry and expect it routed next
    task retire_chk;
        integer     i;
        reg [35:0]  e;
        begin
            e = exq.pop_front();
            retire_i <= 1'b1;
            @(posedge clock_i);
            retire_i <= 1'b0;
            i = 0;
            do begin @(posedge clock_i); i = i + 1; end while (route_valid_o !== 1'b1 && i < 8);
            if (i == 8) hang;
            `CHK("route", e, {route_defer_o, route_tgt_o, route_addr_o})
        end
    endtask
    task t_fill;
        integer i;
        begin
            for (i = 0; i < 12; i = i + 1) do_req(0, 0, 32'h00100000 + i * 64, `HBR_TGT_DRAM, 0);
            `CHK("count", 4'hC, ioq_count_o)
            req_addr_i <= 32'h00200000;
            req_valid_i <= 1'b1;
            repeat (6) @(posedge clock_i);
            `CHK("full_ready", 1'b0, req_ready_o)
            req_valid_i <= 1'b0;
            retire_chk;
            do_req(0, 0, 32'h00200000, `HBR_TGT_DRAM, 0);
            while (exq.size() > 0) retire_chk;
        end
    endtask
    task t_decode;
        do_req(1, 0, 32'h00001FFF, `HBR_TGT_GFX, 0);
        do_req(1, 0, 32'h00000CF8, `HBR_TGT_CFG, 0);
        do_req(1, 0, 32'h00000060, `HBR_TGT_HUB, 0);
        do_req(0, 0, 32'hD0000040, `HBR_TGT_GFX, 0);
        do_req(0, 0, 32'hFFFFFFC0, `HBR_TGT_DRAM, 0);
        while (exq.size() > 0) retire_chk;
    endtask
    // two slots at most, one per interface, freed by completion
    task t_defer;
        do_req(1, 1, 32'h00001000, `HBR_TGT_GFX, 0);
        do_req(1, 1, 32'h00001004, `HBR_TGT_GFX, 1);
        do_req(1, 1, 32'h00000CFC, `HBR_TGT_CFG, 0);
        do_req(1, 1, 32'h00000080, `HBR_TGT_HUB, 1);
        for (n = 1; n < 8; n = n * 2) begin
            defer_done_i <= n[2:0];
            @(posedge clock_i);
            defer_done_i <= 3'h0;
            if (n == 1) do_req(1, 1, 32'h00000080, `HBR_TGT_HUB, 0);
        end
        while (exq.size() > 0) retire_chk;
    endtask
    task in_chk(input [1:0] s, input w, input [31:0] a, input [31:0] ea, input sn, input m);
        integer i;
        begin
            in_src_i <= s;
            in_write_i <= w;
            in_addr_i <= a;
            in_valid_i <= 1'b1;
            i = 0;
            do begin @(posedge clock_i); i = i + 1; end
            while (grant_o[s == `HBR_SRC_HUB ? 3 : 2] !== 1'b1 && i < 60);
            in_valid_i <= 1'b0;
            if (i == 60) hang;
            i = 0;
            do begin @(posedge clock_i); i = i + 1; end while (out_valid_o !== 1'b1 && i < 8);
            if (i == 8) hang;
            `CHK("inbound", {ea, sn, m}, {out_addr_o, out_snoop_o, out_msg_o})
        end
    endtask
    task t_inbound;
        gart_idx_i <= 6'h05;
        gart_page_i <= 20'hABCDE;
        gart_wr_i <= 1'b1;
        @(posedge clock_i);
        gart_wr_i <= 1'b0;
        in_chk(`HBR_SRC_GFX_AGP, 0, 32'h00300047, 32'h00300040, 0, 0);
        in_chk(`HBR_SRC_GFX_PCI, 0, 32'h00300080, 32'h00300080, 1, 0);
        in_chk(`HBR_SRC_HUB, 1, 32'h00300100, 32'h00300100, 1, 0);
        in_chk(`HBR_SRC_GFX_AGP, 0, 32'hE0005123, 32'hABCDE100, 0, 0);
        in_chk(`HBR_SRC_HUB, 0, 32'hE0005040, 32'hABCDE040, 1, 0);
        in_chk(`HBR_SRC_GFX_PCI, 1, 32'hFEE00040, 32'hFEE00040, 0, 1);
        in_chk(`HBR_SRC_HUB, 1, 32'hFEE01000, 32'hFEE01000, 0, 1);
    endtask
    task t_data(input [63:0] v, input [3:0] inv);
        tx_data_i <= v;
        cpu_val <= v;
        repeat (3) @(posedge clock_i);
        `CHK("rx_data", v, rx_data_o)
        `CHK("tx_flags", inv, hd_inv_o)
        `CHK("tx_data", v, rd_data)
    endtask
    // the memory side gets its turn; bus strobe edges counted over 20 periods
    task t_misc;
        integer i;
        begin
            mem_req_i <= 1'b1;
            i = 0;
            do begin @(posedge clock_i); i = i + 1; end while (grant_o[1] !== 1'b1 && i < 40);
            mem_req_i <= 1'b0;
            `CHK("mem_grant", 1'b1, grant_o[1])
            n = 0;
            repeat (320) begin @(posedge clock_i); n = n + bus_edge_o; end
            `CHK("edges", 1'b1, (n >= 19 && n <= 21))
        end
    endtask
    // reset in mid-run empties the queue
    task t_reset;
        do_req(0, 0, 32'h00400000, `HBR_TGT_DRAM, 0);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        `CHK("reset", 13'h0, {ioq_count_o, grant_o, route_valid_o, out_valid_o, req_retry_o, 2'h0})
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        exq.delete();
        do_req(0, 0, 32'h00400040, `HBR_TGT_DRAM, 0);
        retire_chk;
    endtask
    initial begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        t_data(64'h0000FFFF00FF007F, 4'h9);
        t_data(64'hFFFF0001FE0001FF, 4'h6);
        t_fill;
        t_decode;
        t_defer;
        t_inbound;
        t_misc;
        t_reset;
        summarize;
    end
endmodule // hbr_router_tb
